// >>> dcs_pkg.sv
// Constants, register map and carrier types of the converter clock-source controller
`default_nettype none

package dcs_pkg;

    // ==========================================================
    // Bus geometry
    // ==========================================================
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [9:0] IDX_CLK_PWR   = 10'h080;
    localparam logic [9:0] IDX_PLL_CTRL  = 10'h083;
    localparam logic [9:0] IDX_PLL_STAT  = 10'h084;
    localparam logic [9:0] IDX_LOOP_DIV  = 10'h085;
    localparam logic [9:0] IDX_FILT_A    = 10'h087;
    localparam logic [9:0] IDX_FILT_B    = 10'h088;
    localparam logic [9:0] IDX_FILT_C    = 10'h089;
    localparam logic [9:0] IDX_CP_MAIN   = 10'h08A;
    localparam logic [9:0] IDX_VCO_DIV   = 10'h08B;
    localparam logic [9:0] IDX_REF_SEL   = 10'h08C;
    localparam logic [9:0] IDX_REGULATOR = 10'h08D;
    localparam logic [9:0] IDX_PLL_PWR   = 10'h1B0;
    localparam logic [9:0] IDX_CP_AUX_A  = 10'h1B9;
    localparam logic [9:0] IDX_VCO_CTL   = 10'h1BC;
    localparam logic [9:0] IDX_VCO_PWR   = 10'h1BE;
    localparam logic [9:0] IDX_VCO_CAL   = 10'h1BF;
    localparam logic [9:0] IDX_LOCK_LEN  = 10'h1C0;
    localparam logic [9:0] IDX_CP_AUX_B  = 10'h1C1;
    localparam logic [9:0] IDX_VARACTOR  = 10'h1C4;

    // Storage slots, one per register
    localparam int unsigned NSLOT = 19;
    localparam logic [4:0] SL_CLK_PWR   = 5'h00;
    localparam logic [4:0] SL_PLL_CTRL  = 5'h01;
    localparam logic [4:0] SL_PLL_STAT  = 5'h02;
    localparam logic [4:0] SL_LOOP_DIV  = 5'h03;
    localparam logic [4:0] SL_FILT_A    = 5'h04;
    localparam logic [4:0] SL_FILT_B    = 5'h05;
    localparam logic [4:0] SL_FILT_C    = 5'h06;
    localparam logic [4:0] SL_CP_MAIN   = 5'h07;
    localparam logic [4:0] SL_VCO_DIV   = 5'h08;
    localparam logic [4:0] SL_REF_SEL   = 5'h09;
    localparam logic [4:0] SL_REGULATOR = 5'h0A;
    localparam logic [4:0] SL_PLL_PWR   = 5'h0B;
    localparam logic [4:0] SL_CP_AUX_A  = 5'h0C;
    localparam logic [4:0] SL_VCO_CTL   = 5'h0D;
    localparam logic [4:0] SL_VCO_PWR   = 5'h0E;
    localparam logic [4:0] SL_VCO_CAL   = 5'h0F;
    localparam logic [4:0] SL_LOCK_LEN  = 5'h10;
    localparam logic [4:0] SL_CP_AUX_B  = 5'h11;
    localparam logic [4:0] SL_VARACTOR  = 5'h12;
    localparam logic [4:0] SL_NONE      = 5'h1F;

    // ==========================================================
    // Fields and reset values
    // ==========================================================
    localparam int unsigned PWR_CONV0_BIT   = 7;
    localparam int unsigned PWR_CONV1_BIT   = 6;
    localparam int unsigned PWR_DIGITAL_BIT = 5;
    localparam int unsigned PWR_LINK_BIT    = 4;
    localparam int unsigned PWR_RECV_BIT    = 3;
    localparam int unsigned PLL_EN_BIT      = 4;
    localparam int unsigned STAT_LOCK_BIT   = 1;
    localparam int unsigned STAT_CAL_BIT    = 5;
    localparam logic [7:0]  CLK_PWR_RESET   = 8'hF8;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [2:0]  REF_CODE_MAX    = 3'h5;
    localparam logic [7:0]  CAL_REF_CYCLES  = 8'h40;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } dcs_axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic [1:0]        bresp;
        logic              bvalid;
        logic              arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic              rvalid;
    } dcs_axil_rsp_t;

endpackage : dcs_pkg

`default_nettype wire

// >>> dcs_clock_ctrl.sv
// Clock-source selection, domain power and reference-path control with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none

module dcs_clock_ctrl (
    input  wire logic                   CORE_CLK,
    input  wire logic                   RESET,
    input  wire dcs_pkg::dcs_axil_req_t S_AXI_REQ,
    output var  dcs_pkg::dcs_axil_rsp_t S_AXI_RSP,
    input  wire logic                   REF_CLK_IN,
    output var  logic [4:0]             CLK_DOMAIN_ON,
    output var  logic                   SAMPLE_FROM_PLL,
    output var  logic                   PHASE_DET_TICK,
    output var  logic                   PLL_CAL_DONE,
    output var  logic                   PLL_LOCKED,
    output var  logic [7:0]             LOOP_DIVIDE_RATIO,
    output var  logic [1:0]             VCO_OUTPUT_DIVIDER_CODE
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic                                     aw_held;
        logic [dcs_pkg::ADDR_W-1:0]               aw_addr;
        logic                                     w_held;
        logic [dcs_pkg::DATA_W-1:0]               w_data;
        logic [3:0]                               w_strb;
        dcs_pkg::dcs_axil_rsp_t                   rsp;
        logic [dcs_pkg::NSLOT-1:0][7:0]           regs;
        logic                                     ref_s1;
        logic                                     ref_s2;
        logic                                     ref_d;
        logic [4:0]                               div_cnt;
        logic [2:0]                               div_code;
        logic                                     div_tick;
        logic                                     pll_en_d;
        logic [7:0]                               cal_cnt;
        logic                                     cal_done;
        logic [7:0]                               lock_cnt;
        logic                                     locked;
        logic [4:0]                               domain_on;
        logic                                     from_pll;
    } dcs_state_t;

    dcs_state_t state_r;
    dcs_state_t state_nxt;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Byte address to storage slot; unmapped gives SL_NONE
    function automatic logic [4:0] slot_of(input logic [dcs_pkg::ADDR_W-1:0] addr);
        logic [9:0] idx;
        idx = addr[dcs_pkg::ADDR_W-1:2];
        case (idx)
            dcs_pkg::IDX_CLK_PWR:   slot_of = dcs_pkg::SL_CLK_PWR;
            dcs_pkg::IDX_PLL_CTRL:  slot_of = dcs_pkg::SL_PLL_CTRL;
            dcs_pkg::IDX_PLL_STAT:  slot_of = dcs_pkg::SL_PLL_STAT;
            dcs_pkg::IDX_LOOP_DIV:  slot_of = dcs_pkg::SL_LOOP_DIV;
            dcs_pkg::IDX_FILT_A:    slot_of = dcs_pkg::SL_FILT_A;
            dcs_pkg::IDX_FILT_B:    slot_of = dcs_pkg::SL_FILT_B;
            dcs_pkg::IDX_FILT_C:    slot_of = dcs_pkg::SL_FILT_C;
            dcs_pkg::IDX_CP_MAIN:   slot_of = dcs_pkg::SL_CP_MAIN;
            dcs_pkg::IDX_VCO_DIV:   slot_of = dcs_pkg::SL_VCO_DIV;
            dcs_pkg::IDX_REF_SEL:   slot_of = dcs_pkg::SL_REF_SEL;
            dcs_pkg::IDX_REGULATOR: slot_of = dcs_pkg::SL_REGULATOR;
            dcs_pkg::IDX_PLL_PWR:   slot_of = dcs_pkg::SL_PLL_PWR;
            dcs_pkg::IDX_CP_AUX_A:  slot_of = dcs_pkg::SL_CP_AUX_A;
            dcs_pkg::IDX_VCO_CTL:   slot_of = dcs_pkg::SL_VCO_CTL;
            dcs_pkg::IDX_VCO_PWR:   slot_of = dcs_pkg::SL_VCO_PWR;
            dcs_pkg::IDX_VCO_CAL:   slot_of = dcs_pkg::SL_VCO_CAL;
            dcs_pkg::IDX_LOCK_LEN:  slot_of = dcs_pkg::SL_LOCK_LEN;
            dcs_pkg::IDX_CP_AUX_B:  slot_of = dcs_pkg::SL_CP_AUX_B;
            dcs_pkg::IDX_VARACTOR:  slot_of = dcs_pkg::SL_VARACTOR;
            default:                slot_of = dcs_pkg::SL_NONE;
        endcase
    endfunction : slot_of

    // Divider terminal count from the log2 code; codes above 5 clamp to 31 (ratio 32)
    function automatic logic [4:0] ratio_last(input logic [2:0] code);
        logic [2:0] c;
        c = (code > dcs_pkg::REF_CODE_MAX) ? dcs_pkg::REF_CODE_MAX : code;
        ratio_last = 5'((6'h01 << c) - 6'h01);
    endfunction : ratio_last

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic [4:0] wslot;
        logic [4:0] rslot;
        logic       pll_en;
        logic       recv_on;
        logic       ref_rise;
        logic [7:0] lock_len;
        wslot     = slot_of(state_r.aw_addr);
        rslot     = slot_of(S_AXI_REQ.araddr);
        pll_en    = state_r.regs[dcs_pkg::SL_PLL_CTRL][dcs_pkg::PLL_EN_BIT];
        recv_on   = ~state_r.regs[dcs_pkg::SL_CLK_PWR][dcs_pkg::PWR_RECV_BIT];
        ref_rise  = state_r.ref_s2 & ~state_r.ref_d;
        lock_len  = state_r.regs[dcs_pkg::SL_LOCK_LEN];
        state_nxt = state_r;

        // Write address and data are caught independently, in either order
        if (state_r.rsp.awready && S_AXI_REQ.awvalid) begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = S_AXI_REQ.awaddr;
        end
        if (state_r.rsp.wready && S_AXI_REQ.wvalid) begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = S_AXI_REQ.wdata;
            state_nxt.w_strb = S_AXI_REQ.wstrb;
        end
        if (state_r.rsp.bvalid && S_AXI_REQ.bready) begin
            state_nxt.rsp.bvalid = 1'b0;
        end

        // Commit a write once both halves are held and no response is pending
        if (state_r.aw_held && state_r.w_held && !state_r.rsp.bvalid) begin
            state_nxt.aw_held    = 1'b0;
            state_nxt.w_held     = 1'b0;
            state_nxt.rsp.bvalid = 1'b1;
            state_nxt.rsp.bresp  = (wslot == dcs_pkg::SL_NONE) ? dcs_pkg::RESP_DECERR : dcs_pkg::RESP_OKAY;
            // Status is read-only; only byte lane 0 carries register data
            if (wslot != dcs_pkg::SL_NONE && wslot != dcs_pkg::SL_PLL_STAT && state_r.w_strb[0]) begin
                state_nxt.regs[wslot] = state_r.w_data[7:0];
            end
        end

        // Read: one outstanding, answered the cycle after the address is taken
        if (state_r.rsp.rvalid && S_AXI_REQ.rready) begin
            state_nxt.rsp.rvalid = 1'b0;
        end
        if (state_r.rsp.arready && S_AXI_REQ.arvalid) begin
            state_nxt.rsp.rvalid = 1'b1;
            state_nxt.rsp.rdata  = '0;
            state_nxt.rsp.rresp  = dcs_pkg::RESP_OKAY;
            if (rslot == dcs_pkg::SL_NONE) begin
                state_nxt.rsp.rresp = dcs_pkg::RESP_DECERR;
            end else if (rslot == dcs_pkg::SL_PLL_STAT) begin
                state_nxt.rsp.rdata[dcs_pkg::STAT_LOCK_BIT] = state_r.locked;
                state_nxt.rsp.rdata[dcs_pkg::STAT_CAL_BIT]  = state_r.cal_done;
            end else begin
                state_nxt.rsp.rdata[7:0] = state_r.regs[rslot];
            end
        end

        // Ready flags registered so the outputs come straight from flops
        state_nxt.rsp.awready = !state_nxt.aw_held && !state_nxt.rsp.bvalid;
        state_nxt.rsp.wready  = !state_nxt.w_held && !state_nxt.rsp.bvalid;
        state_nxt.rsp.arready = !state_nxt.rsp.rvalid;

        // Reference pin synchroniser; edge detect reads only the second stage
        state_nxt.ref_s1 = REF_CLK_IN;
        state_nxt.ref_s2 = state_r.ref_s1;
        state_nxt.ref_d  = state_r.ref_s2;

        // Enable edge: divider code captured once, so later writes do not disturb a running loop
        state_nxt.pll_en_d = pll_en;
        state_nxt.div_tick = 1'b0;
        if (pll_en && !state_r.pll_en_d) begin
            state_nxt.div_code = state_r.regs[dcs_pkg::SL_REF_SEL][2:0];
            state_nxt.div_cnt  = '0;
            state_nxt.cal_cnt  = '0;
            state_nxt.lock_cnt = '0;
            state_nxt.locked   = 1'b0;
        end else if (!pll_en) begin
            state_nxt.locked = 1'b0;
        end else if (recv_on && ref_rise) begin
            // Reference divider; receiver must be powered for edges to arrive
            if (state_r.div_cnt >= ratio_last(state_r.div_code)) begin
                state_nxt.div_cnt  = '0;
                state_nxt.div_tick = 1'b1;
            end else begin
                state_nxt.div_cnt = state_r.div_cnt + 5'h01;
            end
        end

        // Calibration once at first start, kept for later starts; then lock count
        if (pll_en && state_r.pll_en_d && state_r.div_tick) begin
            if (!state_r.cal_done) begin
                state_nxt.cal_cnt = state_r.cal_cnt + 8'h01;
                if (state_nxt.cal_cnt == dcs_pkg::CAL_REF_CYCLES) begin
                    state_nxt.cal_done = 1'b1;
                end
            end else if (!state_r.locked) begin
                state_nxt.lock_cnt = state_r.lock_cnt + 8'h01;
                // A zero length still needs one detector period
                if (state_nxt.lock_cnt >= lock_len || lock_len == 8'h00) begin
                    state_nxt.locked = 1'b1;
                end
            end
        end

        // Domain power: cleared bit means running
        state_nxt.domain_on = ~state_r.regs[dcs_pkg::SL_CLK_PWR][7:3];

        // Source select follows the enable, not the lock
        state_nxt.from_pll = pll_en;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_r                               <= '0;
            state_r.regs[dcs_pkg::SL_CLK_PWR]     <= dcs_pkg::CLK_PWR_RESET;
            state_r.rsp.awready                   <= 1'b1;
            state_r.rsp.wready                    <= 1'b1;
            state_r.rsp.arready                   <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from state flops
    // ==========================================================
    assign S_AXI_RSP               = state_r.rsp;
    assign CLK_DOMAIN_ON           = state_r.domain_on;
    assign SAMPLE_FROM_PLL         = state_r.from_pll;
    assign PHASE_DET_TICK          = state_r.div_tick;
    assign PLL_CAL_DONE            = state_r.cal_done;
    assign PLL_LOCKED              = state_r.locked;
    assign LOOP_DIVIDE_RATIO       = state_r.regs[dcs_pkg::SL_LOOP_DIV];
    assign VCO_OUTPUT_DIVIDER_CODE = state_r.regs[dcs_pkg::SL_VCO_DIV][1:0];

endmodule : dcs_clock_ctrl

`default_nettype wire

// >>> dcs_clock_ctrl_chk.sv
// Concurrent checks on the ports of the converter clock-source controller
`timescale 1ns/1ns
`default_nettype none
module dcs_clock_ctrl_chk (
    input wire logic                   CORE_CLK,
    input wire logic                   RESET,
    input wire dcs_pkg::dcs_axil_req_t S_AXI_REQ,
    input wire dcs_pkg::dcs_axil_rsp_t S_AXI_RSP,
    input wire logic [4:0]             CLK_DOMAIN_ON,
    input wire logic                   SAMPLE_FROM_PLL,
    input wire logic                   PHASE_DET_TICK,
    input wire logic                   PLL_CAL_DONE,
    input wire logic                   PLL_LOCKED
);
    // ====================
    // Clocking and sequences
    // ====================
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // Both write channels taken at one edge, lane 0 enabled
    sequence s_wr(logic [11:0] a);
        S_AXI_REQ.awvalid && S_AXI_RSP.awready && S_AXI_REQ.wvalid && S_AXI_RSP.wready &&
            S_AXI_REQ.awaddr == a && S_AXI_REQ.wstrb[0];
    endsequence
    // ====================
    // Assertions
    // ====================
    a_reset_all_off: assert property ($fell(RESET) |-> CLK_DOMAIN_ON == 5'h00 && !SAMPLE_FROM_PLL)
        else $error("domains not off after reset");
    a_power_write: assert property (s_wr(12'h200) |-> ##3 CLK_DOMAIN_ON == ~$past(S_AXI_REQ.wdata[7:3], 3))
        else $error("domain power differs from write");
    a_ctrl_select: assert property (s_wr(12'h20C) |-> ##3 SAMPLE_FROM_PLL == $past(S_AXI_REQ.wdata[4], 3))
        else $error("clock source differs from enable");
    a_lock_needs_pll: assert property (PLL_LOCKED |-> SAMPLE_FROM_PLL || $past(SAMPLE_FROM_PLL))
        else $error("lock shown in bypass");
    a_lock_after_cal: assert property (PLL_LOCKED |-> PLL_CAL_DONE)
        else $error("lock before calibration");
    a_cal_sticky: assert property (PLL_CAL_DONE |=> PLL_CAL_DONE)
        else $error("calibration flag dropped");
    a_tick_pulse: assert property (PHASE_DET_TICK |=> !PHASE_DET_TICK)
        else $error("detector tick longer than one cycle");
    a_no_tick_unpowered: assert property ((!CLK_DOMAIN_ON[0]) [*8] |-> !PHASE_DET_TICK)
        else $error("tick with receiver off");
endmodule : dcs_clock_ctrl_chk
bind dcs_clock_ctrl dcs_clock_ctrl_chk i_dcs_clock_ctrl_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .S_AXI_REQ(S_AXI_REQ), .S_AXI_RSP(S_AXI_RSP), .CLK_DOMAIN_ON(CLK_DOMAIN_ON),
    .SAMPLE_FROM_PLL(SAMPLE_FROM_PLL), .PHASE_DET_TICK(PHASE_DET_TICK),
    .PLL_CAL_DONE(PLL_CAL_DONE), .PLL_LOCKED(PLL_LOCKED));
`default_nettype wire

// >>> dcs_ref_source.sv
// Model of the external reference clock source on the clock input pin
`timescale 1ns/1ns
`default_nettype none
module dcs_ref_source (
    input  wire logic       run,
    input  wire logic [7:0] half_ns,
    output var  logic       ref_out
);
    // Toggles only while run; parked low between bursts like a gated source
    initial begin
        ref_out = 1'b0;
        forever begin
            wait (run === 1'b1);
            #(half_ns) ref_out = 1'b1;
            #(half_ns) ref_out = 1'b0;
        end
    end
endmodule : dcs_ref_source
`default_nettype wire

// >>> dac_clock_source_and_pll_setup_bench.sv
// Self-checking bench for the converter clock-source controller
`timescale 1ns/1ns
`default_nettype none
module dac_clock_source_and_pll_setup_bench;
    // ====================
    // Signals and tables
    // ====================
    logic                   clk;
    logic                   rst;
    logic                   ref_run;
    logic                   ref_clk;
    logic [7:0]             ref_half;
    logic [7:0]             d;
    dcs_pkg::dcs_axil_req_t req;
    dcs_pkg::dcs_axil_rsp_t rsp;
    logic [4:0]             dom_on;
    logic                   sel_pll;
    logic                   tick;
    logic                   cal_done;
    logic                   locked;
    logic [7:0]             loop_ratio;
    logic [1:0]             vco_code;
    int                     num_errors;
    int                     cmp_count;
    int                     ref_edges;
    int                     e1;
    int                     t;
    // Byte addresses, power register first
    logic [11:0] regs [19] = '{12'h200, 12'h20C, 12'h210, 12'h214, 12'h21C, 12'h220, 12'h224, 12'h228, 12'h22C,
        12'h230, 12'h234, 12'h6C0, 12'h6E4, 12'h6F0, 12'h6F8, 12'h6FC, 12'h700, 12'h704, 12'h710};
    // Recommended fixed writes
    logic [11:0] fix_a [13] = '{12'h21C, 12'h220, 12'h224, 12'h228, 12'h234, 12'h6C0, 12'h6E4, 12'h6F0,
        12'h6F8, 12'h6FC, 12'h700, 12'h704, 12'h710};
    logic [7:0]  fix_d [13] = '{8'h62, 8'hC9, 8'h0E, 8'h12, 8'h7B, 8'h00, 8'h24, 8'h0D, 8'h02, 8'h8E, 8'h2A,
        8'h2A, 8'h7E};
    // ====================
    // Clock, instances, edge monitor
    // ====================
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge ref_clk) ref_edges++;
    dcs_clock_ctrl i_dcs_clock_ctrl (.CORE_CLK(clk), .RESET(rst), .S_AXI_REQ(req), .S_AXI_RSP(rsp),
        .REF_CLK_IN(ref_clk), .CLK_DOMAIN_ON(dom_on), .SAMPLE_FROM_PLL(sel_pll), .PHASE_DET_TICK(tick),
        .PLL_CAL_DONE(cal_done), .PLL_LOCKED(locked), .LOOP_DIVIDE_RATIO(loop_ratio),
        .VCO_OUTPUT_DIVIDER_CODE(vco_code));
    dcs_ref_source i_dcs_ref_source (.run(ref_run), .half_ns(ref_half), .ref_out(ref_clk));
    // ====================
    // Tasks
    // ====================
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bus write; first edge spent so no signal is assigned twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] er);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= dat;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        // No cycle limit of its own: a hung answer is left to the watchdog
        do begin
            @(posedge clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, rsp.bresp});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rsp.rresp});
        chk($sformatf("rdata %h", a), ed, rsp.rdata);
    endtask : rd
    // Count detector ticks until calibration (sel 0) or lock (sel 1)
    task automatic cnt_ticks(input bit sel);
        int n;
        n = 0;
        t = 0;
        do begin
            @(negedge clk);
            n++;
            if (tick === 1'b1) t++;
        end while (((sel ? locked : cal_done) !== 1'b1) && n < 20000);
    endtask : cnt_ticks
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 5000);
    endtask : wait_tick
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // ====================
    // Watchdog, well above the expected run of some 60 us
    // ====================
    initial begin
        #1000000;
        num_errors++;
        $display("FAIL watchdog expected done seen timeout");
        finish_test();
    end
    // ====================
    // Main sequence
    // ====================
    initial begin
        req = '0;
        rst = 1'b1;
        ref_run = 1'b0;
        ref_half = 8'h32;
        num_errors = 0;
        cmp_count = 0;
        ref_edges = 0;
        void'($urandom(68726));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 19; i++) rd(regs[i], 2'h0, (i == 0) ? 32'hF8 : 32'h0);
        chk("domains", 32'h0, {27'h0, dom_on});
        wr(12'h208, $urandom, 2'h3);
        rd(12'h208, 2'h3, 32'h0);
        wr(12'h210, 32'hFF, 2'h0);
        rd(12'h210, 2'h0, 32'h0);
        $display("test reset_and_map done");
        // Walking one, random, then all-zero power words
        for (int i = 0; i < 10; i++) begin
            d = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'($urandom) : 8'h00);
            wr(12'h200, {24'($urandom), d}, 2'h0);
            repeat (2) @(negedge clk);
            chk("domains", {27'h0, ~d[7:3]}, {27'h0, dom_on});
            rd(12'h200, 2'h0, {24'h0, d});
        end
        $display("test domain_power done");
        for (int i = 0; i < 13; i++) wr(fix_a[i], {24'($urandom), fix_d[i]}, 2'h0);
        for (int i = 0; i < 13; i++) rd(fix_a[i], 2'h0, {24'h0, fix_d[i]});
        d = 8'h06 + 8'($urandom % 122);
        wr(12'h214, {24'h0, d}, 2'h0);
        repeat (2) @(negedge clk);
        chk("loop ratio", {24'h0, d}, {24'h0, loop_ratio});
        for (int c = 1; c < 4; c++) begin
            wr(12'h22C, c, 2'h0);
            repeat (2) @(negedge clk);
            chk("vco code", c, {30'h0, vco_code});
        end
        $display("test fixed_writes done");
        // Configure first, then enable; source speed drawn at random
        wr(12'h230, 32'h0, 2'h0);
        ref_half = 8'd50 + 8'($urandom % 31);
        wr(12'h20C, 32'h10, 2'h0);
        repeat (2) @(negedge clk);
        chk("pll select", 32'h1, {31'h0, sel_pll});
        // Source starts only now, so no tick can slip in before counting begins
        ref_run <= 1'b1;
        cnt_ticks(1'b0);
        chk("cal ticks", 32'd64, t);
        cnt_ticks(1'b1);
        chk("lock ticks", 32'd42, t);
        rd(12'h210, 2'h0, 32'h22);
        $display("test calibrate_lock done");
        // Codes 6 and 7 are expected to act as the largest ratio
        for (int c = 0; c < 8; c++) begin
            wr(12'h20C, 32'h0, 2'h0);
            repeat (3) @(negedge clk);
            chk("bypass", 32'h1, {29'h0, sel_pll, locked, cal_done});
            wr(12'h230, c, 2'h0);
            wr(12'h20C, 32'h10, 2'h0);
            wait_tick();
            e1 = ref_edges;
            wait_tick();
            chk("ref ratio", 32'h1 << ((c > 5) ? 5 : c), ref_edges - e1);
        end
        $display("test ref_divider done");
        wr(12'h200, 32'h08, 2'h0);
        cnt_ticks(1'b0);
        t = 0;
        repeat (400) @(negedge clk) if (tick === 1'b1) t++;
        chk("ticks unpowered", 32'h0, t);
        ref_run <= 1'b0;
        $display("test receiver_off done");
        finish_test();
    end
endmodule : dac_clock_source_and_pll_setup_bench
`default_nettype wire
